//--- rtl/rtf_framer.sv
// trigger action selection, action timeouts and serial response framing
`timescale 1ns/1ps
`default_nettype none
module rtf_framer
  import rtf_pkg::*;
#(
  parameter int TRIG_HOLD = TRIG_HOLD_CYCLES,
  parameter int SLICE = SLICE_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic trig1_pin,
  input wire logic trig2_pin,
  input wire logic setup_mode,
  input wire logic [1:0] antenna_selection,
  input wire logic cfg_wr,
  input wire rtf_pkg::rtf_cfg_t cfg_sel,
  input wire logic [1:0] cfg_len,
  input wire logic [7:0] cfg_char0,
  input wire logic [7:0] cfg_char1,
  input wire logic [7:0] cfg_char2,
  output logic cfg_reject,
  output logic [2:0] first_trigger_action,
  output logic [2:0] second_trigger_action,
  output logic [7:0] first_trigger_timeout,
  output logic [7:0] second_trigger_timeout,
  output logic [7:0] response_prefix_byte,
  output logic [7:0] response_suffix_byte,
  output logic serial_tag_lockout,
  output logic [1:0] active_antenna,
  output logic op_start,
  output logic op_abort,
  output logic op_inventory,
  output logic [1:0] op_antenna,
  output logic op_both,
  output logic action_timeout,
  input wire logic op_done,
  input wire logic op_ok,
  input wire logic msg_start,
  input wire rtf_pkg::rtf_msg_t msg_kind,
  input wire rtf_pkg::rtf_err_t msg_err,
  input wire logic [7:0] msg_flags,
  input wire logic [1:0] msg_antenna,
  input wire logic din_valid,
  input wire logic [7:0] din_byte,
  input wire logic din_last,
  output logic din_ready,
  output logic msg_busy,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_byte
);
  import rtf_pkg::*;

  localparam int HW = $clog2(TRIG_HOLD + 1);
  localparam int SW = $clog2(SLICE + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(TRIG_HOLD - 1);
  localparam logic [SW-1:0] SLICE_LAST = SW'(SLICE - 1);

  typedef enum logic [1:0] {A_IDLE = 2'b01, A_RUN = 2'b10} rtf_act_t;
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001, S_HDR = 7'b0000010, S_ANT = 7'b0000100, S_FLAG = 7'b0001000,
    S_PRE = 7'b0010000, S_BODY = 7'b0100000, S_TRL = 7'b1000000
  } rtf_stage_t;

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= CH_ZERO) && (c <= CH_NINE);
  endfunction

  function automatic logic [9:0] dec_val(input logic [7:0] c);
    return {6'h00, c[3:0]};
  endfunction

  function automatic logic [3:0] err_len(input rtf_err_t e);
    case (e)
      ERR_COLL: return 4'h4;
      ERR_MISREAD: return 4'h7;
      default: return 4'h6;
    endcase
  endfunction

  function automatic logic [7:0] err_char(input rtf_err_t e, input logic [3:0] i);
    logic [55:0] t;
    logic [3:0] pos;
    case (e)
      ERR_NO_TAG: t = TXT_NO_TAG;
      ERR_NO_ANT: t = TXT_NO_ANT;
      ERR_COLL: t = TXT_COLL;
      default: t = TXT_MISREAD;
    endcase
    pos = err_len(e) - 4'h1 - i;
    return t[8*pos +: 8];
  endfunction

  // reserved flag codes are folded into the unspecified error
  function automatic logic [7:0] iso_norm(input logic [7:0] f);
    case (f)
      ISO_OK, ISO_UNSUP_CMD, ISO_UNREC_CMD, ISO_UNSUP_OPT, ISO_UNSPEC, ISO_NO_BLOCK,
      ISO_ALREADY_LOCKED, ISO_LOCKED, ISO_PROG_FAIL, ISO_LOCK_FAIL: return f;
      default: return ISO_UNSPEC;
    endcase
  endfunction

  function automatic rtf_stage_t stage_after(input logic [6:0] cur, input logic [6:0] en);
    logic [6:0] r;
    logic hit;
    r = S_IDLE;
    hit = 1'b0;
    for (int i = 1; i < 7; i++) begin
      if (!hit && en[i] && ((7'h01 << i) > cur)) begin
        r = 7'h01 << i;
        hit = 1'b1;
      end
    end
    return rtf_stage_t'(r);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // configuration decode
  logic [9:0] wait_val;
  logic wait_ok;
  logic [7:0] byte_val;
  logic byte_ok;

  assign wait_val = dec_val(cfg_char0) * 10'd100 + dec_val(cfg_char1) * 10'd10
    + dec_val(cfg_char2);
  assign wait_ok = cfg_len == 2'h3 && is_digit(cfg_char0) && is_digit(cfg_char1)
    && is_digit(cfg_char2) && wait_val >= TMO_MIN && wait_val <= TMO_MAX;

  always_comb begin
    byte_ok = 1'b1;
    byte_val = cfg_char0;
    if (cfg_len == 2'h2 && cfg_char0 == CH_C && cfg_char1 == CH_R) begin
      byte_val = CH_CR;
    end else if (cfg_len == 2'h2 && cfg_char0 == CH_ZERO && cfg_char1 == CH_ZERO) begin
      byte_val = CH_NUL;
    end else if (cfg_len != 2'h1) begin
      byte_ok = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      first_trigger_action <= ACT_NONE;
      second_trigger_action <= ACT_NONE;
      first_trigger_timeout <= TMO_DEFAULT;
      second_trigger_timeout <= TMO_DEFAULT;
      response_prefix_byte <= CH_NUL;
      response_suffix_byte <= CH_NUL;
      cfg_reject <= 1'b0;
    end else begin
      cfg_reject <= 1'b0;
      if (cfg_wr) begin
        case (cfg_sel)
          CFG_TRIG1: if (cfg_len == 2'h1 && is_digit(cfg_char0)
              && cfg_char0[3:0] <= {1'b0, FIRST_ACT_MAX}) first_trigger_action <= cfg_char0[2:0];
            else cfg_reject <= 1'b1;
          CFG_TRIG2: if (cfg_len == 2'h1 && is_digit(cfg_char0)
              && cfg_char0[3:0] <= {1'b0, SECOND_ACT_MAX}) second_trigger_action <= cfg_char0[2:0];
            else cfg_reject <= 1'b1;
          CFG_WAIT1: if (wait_ok) first_trigger_timeout <= wait_val[7:0];
            else cfg_reject <= 1'b1;
          CFG_WAIT2: if (wait_ok) second_trigger_timeout <= wait_val[7:0];
            else cfg_reject <= 1'b1;
          CFG_PREFIX: if (byte_ok) response_prefix_byte <= byte_val;
            else cfg_reject <= 1'b1;
          CFG_SUFFIX: if (byte_ok) response_suffix_byte <= byte_val;
            else cfg_reject <= 1'b1;
          default: cfg_reject <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      serial_tag_lockout <= 1'b0;
    end else begin
      serial_tag_lockout <= first_trigger_action != ACT_NONE
        || second_trigger_action != ACT_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // trigger inputs: synchronise, then accept only a level held for the full hold time
  logic [1:0] trig_meta;
  logic [1:0] trig_sync;
  logic [1:0] trig_filt;
  logic [1:0] trig_rise;
  logic [HW-1:0] hold_cnt [2];

  always_ff @(posedge mclk) begin
    if (reset) begin
      trig_meta <= 2'h0;
      trig_sync <= 2'h0;
    end else begin
      trig_meta <= {trig2_pin, trig1_pin};
      trig_sync <= trig_meta;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      trig_filt <= 2'h0;
      trig_rise <= 2'h0;
      hold_cnt <= '{default: '0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        trig_rise[i] <= 1'b0;
        if (trig_sync[i] == trig_filt[i]) begin
          hold_cnt[i] <= '0;
        end else if (hold_cnt[i] == HOLD_LAST) begin
          hold_cnt[i] <= '0;
          trig_filt[i] <= trig_sync[i];
          trig_rise[i] <= trig_sync[i];
        end else begin
          hold_cnt[i] <= hold_cnt[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      active_antenna <= ANT_ONE;
    end else if (antenna_selection == ANTSEL_TRIG_SWITCHED) begin
      if (trig_rise[0]) active_antenna <= ANT_ONE;
      else if (trig_rise[1]) active_antenna <= ANT_TWO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // trigger actions and their timeouts
  rtf_act_t a_state;
  logic run_second;
  logic [2:0] run_code;
  logic [SW-1:0] slice_cnt;
  logic [7:0] slice_num;
  logic hold_mode;
  logic slice_end;

  assign hold_mode = !run_second && (run_code == ACT_READ_HOLD || run_code == ACT_INV_HOLD);
  assign slice_end = slice_cnt == SLICE_LAST;

  always_ff @(posedge mclk) begin
    if (reset) begin
      a_state <= A_IDLE;
      run_second <= 1'b0;
      run_code <= ACT_NONE;
      slice_cnt <= '0;
      slice_num <= 8'h00;
      op_start <= 1'b0;
      op_abort <= 1'b0;
      op_inventory <= 1'b0;
      op_antenna <= ANT_ONE;
      op_both <= 1'b0;
      action_timeout <= 1'b0;
    end else begin
      op_start <= 1'b0;
      op_abort <= 1'b0;
      action_timeout <= 1'b0;
      slice_cnt <= slice_end ? '0 : slice_cnt + 1'b1;
      case (a_state)
        A_IDLE: begin
          slice_cnt <= '0;
          slice_num <= 8'h00;
          if (trig_rise[0] && first_trigger_action != ACT_NONE) begin
            a_state <= A_RUN;
            run_second <= 1'b0;
            run_code <= first_trigger_action;
            op_start <= 1'b1;
            op_antenna <= ANT_ONE;
            op_inventory <= !first_trigger_action[0];
            op_both <= first_trigger_action >= ACT_READ_BOTH;
          end else if (trig_rise[1] && second_trigger_action != ACT_NONE
              && first_trigger_action != ACT_READ_HOLD
              && first_trigger_action != ACT_INV_HOLD) begin
            a_state <= A_RUN;
            run_second <= 1'b1;
            run_code <= second_trigger_action;
            op_start <= 1'b1;
            op_antenna <= ANT_TWO;
            op_inventory <= !second_trigger_action[0];
            op_both <= second_trigger_action >= ACT_READ_BOTH;
          end
        end
        A_RUN: begin
          if (slice_end) slice_num <= slice_num + 8'h01;
          if (trig_rise[1] && hold_mode) begin
            op_abort <= 1'b1;
            a_state <= A_IDLE;
          end else if (slice_end && slice_num + 8'h01 ==
              (run_second ? second_trigger_timeout : first_trigger_timeout)) begin
            op_abort <= 1'b1;
            action_timeout <= 1'b1;
            a_state <= A_IDLE;
          end else if (op_done) begin
            if (hold_mode && !op_ok) op_start <= 1'b1;
            else a_state <= A_IDLE;
          end
        end
        default: a_state <= A_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // response framing into the output buffer
  rtf_stage_t state;
  rtf_stage_t next_state;
  logic [6:0] en;
  logic [6:0] en_new;
  rtf_msg_t kind;
  rtf_err_t err;
  logic [7:0] flags;
  logic [1:0] ant;
  logic [3:0] idx;
  logic push;
  logic [7:0] pbyte;
  logic adv;
  logic buf_ready;
  logic stream_body;

  assign stream_body = state == S_BODY && kind != MSG_ERROR;
  assign din_ready = stream_body && buf_ready;
  // setup mode suppresses prefix and suffix outright
  assign en_new = {!setup_mode && response_suffix_byte != CH_NUL, 1'b1,
    msg_kind == MSG_DISPLAY, msg_kind == MSG_DATA,
    msg_kind != MSG_DISPLAY && antenna_selection != 2'h0,
    !setup_mode && response_prefix_byte != CH_NUL, 1'b0};

  always_comb begin
    push = 1'b1;
    pbyte = CH_NUL;
    adv = 1'b0;
    next_state = state;
    case (state)
      S_IDLE: begin
        push = 1'b0;
        if (msg_start) next_state = stage_after(S_IDLE, en_new);
      end
      S_HDR: begin
        pbyte = response_prefix_byte;
        adv = buf_ready;
      end
      S_ANT: begin
        pbyte = CH_ZERO + {6'h00, ant};
        adv = buf_ready;
      end
      S_FLAG: begin
        pbyte = iso_norm(flags);
        adv = buf_ready;
      end
      S_PRE: begin
        pbyte = DISP_PREAMBLE[8*(DISP_PREAMBLE_LEN - 3'h1 - idx[2:0]) +: 8];
        adv = buf_ready && idx == {1'b0, DISP_PREAMBLE_LEN - 3'h1};
      end
      S_BODY: begin
        if (kind == MSG_ERROR) begin
          pbyte = err_char(err, idx);
          adv = buf_ready && idx == err_len(err) - 4'h1;
        end else begin
          push = din_valid;
          pbyte = din_byte;
          adv = buf_ready && din_valid && din_last;
        end
      end
      S_TRL: begin
        pbyte = response_suffix_byte;
        adv = buf_ready;
      end
      default: begin
        push = 1'b0;
        next_state = S_IDLE;
      end
    endcase
    if (adv) next_state = stage_after(state, en);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= S_IDLE;
      msg_busy <= 1'b0;
      idx <= 4'h0;
    end else begin
      state <= next_state;
      msg_busy <= next_state != S_IDLE;
      if (adv || state == S_IDLE) idx <= 4'h0;
      else if (push && buf_ready) idx <= idx + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      en <= 7'h00;
      kind <= MSG_DATA;
      err <= ERR_NO_TAG;
      flags <= ISO_OK;
      ant <= ANT_ONE;
    end else if (state == S_IDLE && msg_start) begin
      en <= en_new;
      kind <= msg_kind;
      err <= msg_err;
      flags <= msg_flags;
      ant <= msg_antenna;
    end
  end

  rtf_pair_buf #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
    .mclk(mclk),
    .reset(reset),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(pbyte),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_byte)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  sequence seq_hold_run;
    a_state == A_RUN && hold_mode && trig_rise[1];
  endsequence
  sequence seq_stop_only;
    op_abort && !op_start ##1 a_state == A_IDLE && !op_start;
  endsequence

  chk_idle_second_off: assert property (a_state == A_IDLE && trig_rise[1] && !trig_rise[0]
    && second_trigger_action == ACT_NONE |=> !op_start)
    else $error("second trigger started an action while disabled");
  chk_second_antenna: assert property ($rose(op_start) && run_second |->
    op_antenna == ANT_TWO && op_inventory == !run_code[0])
    else $error("second trigger action on wrong antenna or kind");
  chk_both_outputs: assert property (op_start && run_second |->
    op_both == (run_code >= ACT_READ_BOTH))
    else $error("both-output choice wrong for second trigger");
  chk_serial_lockout: assert property (##1 serial_tag_lockout ==
    ($past(first_trigger_action) != ACT_NONE || $past(second_trigger_action) != ACT_NONE))
    else $error("serial lockout does not follow trigger actions");
  chk_hold_stop: assert property (seq_hold_run |=> seq_stop_only)
    else $error("second trigger did not just stop the held action");
  chk_wait_range: assert property (first_trigger_timeout >= TMO_MIN[7:0]
    && second_trigger_timeout >= TMO_MIN[7:0])
    else $error("trigger timeout below its least value");
  chk_setup_no_prefix: assert property (state == S_IDLE && msg_start && setup_mode |=>
    state != S_HDR ##1 state != S_HDR)
    else $error("prefix emitted in setup mode");
  chk_prefix_byte: assert property (state == S_HDR && push |-> pbyte == response_prefix_byte
    && pbyte != CH_NUL)
    else $error("prefix byte wrong");
  chk_suffix_byte: assert property (state == S_TRL && push |-> pbyte == response_suffix_byte
    && !setup_mode)
    else $error("suffix byte wrong");
  chk_cr_pair: assert property (cfg_wr && cfg_sel == CFG_PREFIX && cfg_len == 2'h2
    && cfg_char0 == CH_C && cfg_char1 == CH_R |=> response_prefix_byte == CH_CR)
    else $error("carriage return pair not decoded");
  chk_zero_pair: assert property (cfg_wr && cfg_sel == CFG_SUFFIX && cfg_len == 2'h2
    && cfg_char0 == CH_ZERO && cfg_char1 == CH_ZERO |=> response_suffix_byte == CH_NUL)
    else $error("zero pair not decoded");
  chk_display_lead: assert property (state == S_PRE && idx == 4'h0 && push |->
    pbyte == CH_CR)
    else $error("display reply does not open with carriage return");
  chk_flag_data_only: assert property (state == S_FLAG |-> kind == MSG_DATA)
    else $error("flag byte in a non-data reply");
  chk_timeout_abort: assert property (action_timeout |-> op_abort ##1 a_state == A_IDLE)
    else $error("timeout did not end the action");
endmodule
`default_nettype wire

//--- include/rtf_pkg.sv
// constants and types shared by the trigger action and response framing logic
package rtf_pkg;
  // timing: clock rate, the 10 ms slice used by timeouts and the 10 ms trigger filter hold time
  localparam int CLK_HZ = 40_000_000;
  localparam int SLICE_MS = 10;
  localparam int SLICE_CYCLES = CLK_HZ / 1000 * SLICE_MS;
  localparam int TRIG_HOLD_MS = 10;
  localparam int TRIG_HOLD_CYCLES = CLK_HZ / 1000 * TRIG_HOLD_MS;
  localparam int BUF_DEPTH = 2;

  // timeout settings, in slices
  localparam logic [7:0] TMO_DEFAULT = 8'h05;
  localparam logic [9:0] TMO_MIN = 10'h005;
  localparam logic [9:0] TMO_MAX = 10'h0ff;
  localparam logic [7:0] INVENTORY_TMO_MIN = 8'h0d;

  // trigger action codes
  localparam logic [2:0] ACT_NONE = 3'h0;
  localparam logic [2:0] ACT_READ = 3'h1;
  localparam logic [2:0] ACT_INV = 3'h2;
  localparam logic [2:0] ACT_READ_BOTH = 3'h3;
  localparam logic [2:0] ACT_INV_BOTH = 3'h4;
  localparam logic [2:0] ACT_READ_HOLD = 3'h5;
  localparam logic [2:0] ACT_INV_HOLD = 3'h6;
  localparam logic [2:0] FIRST_ACT_MAX = 3'h6;
  localparam logic [2:0] SECOND_ACT_MAX = 3'h4;
  localparam logic [1:0] ANT_ONE = 2'h1;
  localparam logic [1:0] ANT_TWO = 2'h2;
  localparam logic [1:0] ANTSEL_TRIG_SWITCHED = 2'h1;

  // characters
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [47:0] DISP_PREAMBLE = 48'h0d0a02060d0a;
  localparam logic [2:0] DISP_PREAMBLE_LEN = 3'h6;

  // error texts, right aligned
  localparam logic [55:0] TXT_NO_TAG = "NO TAG";
  localparam logic [55:0] TXT_NO_ANT = "NO ANT";
  localparam logic [55:0] TXT_COLL = "COLL";
  localparam logic [55:0] TXT_MISREAD = "MISREAD";

  // iso flag byte codes
  localparam logic [7:0] ISO_OK = 8'h00;
  localparam logic [7:0] ISO_UNSUP_CMD = 8'h01;
  localparam logic [7:0] ISO_UNREC_CMD = 8'h02;
  localparam logic [7:0] ISO_UNSUP_OPT = 8'h03;
  localparam logic [7:0] ISO_UNSPEC = 8'h0f;
  localparam logic [7:0] ISO_NO_BLOCK = 8'h10;
  localparam logic [7:0] ISO_ALREADY_LOCKED = 8'h11;
  localparam logic [7:0] ISO_LOCKED = 8'h12;
  localparam logic [7:0] ISO_PROG_FAIL = 8'h13;
  localparam logic [7:0] ISO_LOCK_FAIL = 8'h14;

  typedef enum logic [1:0] {MSG_DATA = 2'h0, MSG_ERROR = 2'h1, MSG_DISPLAY = 2'h2} rtf_msg_t;
  typedef enum logic [1:0] {
    ERR_NO_TAG = 2'h0, ERR_NO_ANT = 2'h1, ERR_COLL = 2'h2, ERR_MISREAD = 2'h3
  } rtf_err_t;
  typedef enum logic [2:0] {
    CFG_TRIG1 = 3'h0, CFG_TRIG2 = 3'h1, CFG_WAIT1 = 3'h2,
    CFG_WAIT2 = 3'h3, CFG_PREFIX = 3'h4, CFG_SUFFIX = 3'h5
  } rtf_cfg_t;
endpackage

//--- rtl/rtf_pair_buf.sv
// shift-register buffer between the framer and the serial transmitter
`timescale 1ns/1ps
`default_nettype none
module rtf_pair_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] next_mem [DEPTH];
  logic [DEPTH-1:0] v;
  logic [DEPTH-1:0] next_v;
  logic push;
  logic pop;
  logic placed;

  // entry 0 is the head, so the outputs come straight from flops
  assign in_ready = !v[DEPTH-1];
  assign out_valid = v[0];
  assign out_data = mem[0];
  assign push = in_valid && in_ready;
  assign pop = v[0] && out_ready;

  always_comb begin
    placed = 1'b0;
    next_v = v;
    next_mem = mem;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_v[i] = v[i+1];
        next_mem[i] = mem[i+1];
      end
      next_v[DEPTH-1] = 1'b0;
    end
    if (push) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !next_v[i]) begin
          next_v[i] = 1'b1;
          next_mem[i] = in_data;
          placed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      v <= '0;
    end else begin
      v <= next_v;
    end
  end

  always_ff @(posedge mclk) begin
    mem <= next_mem;
  end
endmodule
`default_nettype wire

//--- test/rtf_tx_sink.sv
// serial transmitter model: takes framed bytes, stalls one cycle in three
`timescale 1ns/1ps
`default_nettype none
module rtf_tx_sink (
  input wire logic mclk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  logic [1:0] n = 2'h0;
  logic [7:0] q[$];
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) q.push_back(tx_byte);
    n <= (n == 2'h2) ? 2'h0 : n + 2'h1;
  end
  // the stall makes the two-entry buffer fill up
  assign tx_ready = (n != 2'h0);
endmodule
`default_nettype wire

//--- test/rtf_framer_tb.sv
// self-checking bench for the trigger action and response framer
`timescale 1ns/1ps
`default_nettype none
module rtf_framer_tb;
  import rtf_pkg::*;
  logic mclk = '0, reset = '1, trig1_pin = '0, trig2_pin = '0, setup_mode = '0, cfg_wr = '0;
  logic op_done = '0, op_ok = '0, msg_start = '0, din_valid = '0, din_last = '0;
  logic [1:0] antenna_selection = '0, cfg_len = '0, msg_antenna = 2'h2;
  logic [7:0] cfg_char0 = '0, cfg_char1 = '0, cfg_char2 = '0, msg_flags = '0, din_byte = '0;
  rtf_cfg_t cfg_sel = CFG_TRIG1;
  rtf_msg_t msg_kind = MSG_DATA;
  rtf_err_t msg_err = ERR_COLL;
  logic cfg_reject, serial_tag_lockout, op_start, op_abort, op_inventory, op_both;
  logic action_timeout, din_ready, msg_busy, tx_valid, tx_ready;
  logic [2:0] first_trigger_action, second_trigger_action;
  logic [7:0] first_trigger_timeout, second_trigger_timeout, tx_byte;
  logic [7:0] response_prefix_byte, response_suffix_byte;
  logic [1:0] active_antenna, op_antenna;
  int num_errors = 0, checked = 0;
  // short filter and slice so a timeout fits in a few hundred cycles
  rtf_framer #(.TRIG_HOLD(8), .SLICE(16)) DUT (.*);
  rtf_tx_sink sink (.mclk(mclk), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));
  initial forever #12.5 mclk = ~mclk;
  task chk(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task tick;
    @(posedge mclk);
    #2;
  endtask
  task cfg(input rtf_cfg_t s, input logic [1:0] n, input logic [23:0] c, input logic rej);
    tick;
    cfg_wr = 1'h1;
    cfg_sel = s;
    cfg_len = n;
    {cfg_char0, cfg_char1, cfg_char2} = c;
    tick;
    cfg_wr = 1'h0;
    chk("cfg_reject", cfg_reject, rej);
  endtask
  task reply(input rtf_msg_t k, input logic [7:0] e[$]);
    sink.q.delete();
    tick;
    msg_start = 1'h1;
    msg_kind = k;
    tick;
    msg_start = 1'h0;
    chk("msg_busy", msg_busy, 8'h01);
    // display replies carry their table over the same body stream as data
    if (k != MSG_ERROR) begin
      din_valid = 1'h1;
      din_byte = 8'h41;
      din_last = 1'h1;
      while (din_ready !== 1'b1) tick;
      tick;
      din_valid = 1'h0;
    end
    repeat (40) tick;
    chk("tx_valid", tx_valid, 8'h00);
    chk("count", sink.q.size(), e.size());
    foreach (e[i]) chk("tx_byte", sink.q[i], e[i]);
  endtask
  task t_reset;
    chk("action2", second_trigger_action, 8'h00);
    chk("timeout1", first_trigger_timeout, 8'h05);
    chk("timeout2", second_trigger_timeout, 8'h05);
    chk("prefix", response_prefix_byte, 8'h00);
    $display("done reset");
  endtask
  task t_cfg;
    cfg(CFG_WAIT1, 2'h3, "013", 1'h0);
    chk("timeout1", first_trigger_timeout, 8'h0d);
    cfg(CFG_WAIT2, 2'h3, "004", 1'h1);
    chk("timeout2", second_trigger_timeout, 8'h05);
    cfg(CFG_PREFIX, 2'h2, {"CR", 8'h00}, 1'h0);
    chk("prefix", response_prefix_byte, 8'h0d);
    cfg(CFG_SUFFIX, 2'h1, {"Z", 16'h0000}, 1'h0);
    chk("suffix", response_suffix_byte, 8'h5a);
    $display("done cfg");
  endtask
  task t_frames;
    antenna_selection = 2'h2;
    msg_flags = 8'h12;
    reply(MSG_DATA, '{8'h0d, 8'h32, 8'h12, 8'h41, 8'h5a});
    setup_mode = 1'h1;
    reply(MSG_ERROR, '{8'h32, "C", "O", "L", "L"});
    setup_mode = 1'h0;
    cfg(CFG_PREFIX, 2'h2, {"00", 8'h00}, 1'h0);
    chk("prefix", response_prefix_byte, 8'h00);
    reply(MSG_DISPLAY, '{8'h0d, 8'h0a, 8'h02, 8'h06, 8'h0d, 8'h0a, 8'h41, 8'h5a});
    cfg(CFG_SUFFIX, 2'h2, {"00", 8'h00}, 1'h0);
    chk("suffix", response_suffix_byte, 8'h00);
    $display("done frames");
  endtask
  task t_trig;
    // a second trigger with its action at zero must start nothing
    trig2_pin = 1'h1;
    for (int i = 0; i < 16 && op_start !== 1'b1; i++) tick;
    chk("op_start", op_start, 8'h00);
    chk("lockout", serial_tag_lockout, 8'h00);
    trig2_pin = 1'h0;
    // let the filtered level fall back before the next rise
    repeat (12) tick;
    antenna_selection = 2'h1;
    cfg(CFG_TRIG2, 2'h1, {"1", 16'h0000}, 1'h0);
    tick;
    chk("lockout", serial_tag_lockout, 8'h01);
    trig2_pin = 1'h1;
    for (int i = 0; i < 30 && op_start !== 1'b1; i++) tick;
    chk("op_start", op_start, 8'h01);
    chk("op_antenna", op_antenna, 8'h02);
    chk("op_inventory", op_inventory, 8'h00);
    chk("op_both", op_both, 8'h00);
    chk("active_antenna", active_antenna, 8'h02);
    trig2_pin = 1'h0;
    for (int i = 0; i < 120 && action_timeout !== 1'b1; i++) tick;
    chk("action_timeout", action_timeout, 8'h01);
    chk("op_abort", op_abort, 8'h01);
    cfg(CFG_TRIG1, 2'h1, {"5", 16'h0000}, 1'h0);
    chk("action1", first_trigger_action, 8'h05);
    trig1_pin = 1'h1;
    for (int i = 0; i < 30 && op_start !== 1'b1; i++) tick;
    chk("op_both", op_both, 8'h01);
    chk("active_antenna", active_antenna, 8'h01);
    trig1_pin = 1'h0;
    trig2_pin = 1'h1;
    for (int i = 0; i < 30 && op_abort !== 1'b1; i++) tick;
    chk("op_abort", op_abort, 8'h01);
    chk("action_timeout", action_timeout, 8'h00);
    trig2_pin = 1'h0;
    for (int i = 0; i < 20 && op_start !== 1'b1; i++) tick;
    chk("op_start", op_start, 8'h00);
    $display("done trig");
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) tick;
    reset = 1'h0;
    t_reset;
    t_cfg;
    t_frames;
    t_trig;
    print_verdict;
  end
  // whole run is about 320 cycles, eight microseconds
  initial begin
    #50us;
    num_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
